//--- pcf_regs.svh
// Named constants for the gated clock fanout block
`ifndef PCF_REGS_SVH
`define PCF_REGS_SVH
`define PCF_SYS_CLK_KHZ     40000
`define PCF_STAB_TIME_US    1000
`define PCF_STAB_CYCLES     ((`PCF_STAB_TIME_US * `PCF_SYS_CLK_KHZ) / 1000)
`define PCF_BANK_A_WIDTH    5
`define PCF_BANK_B_WIDTH    4
`define PCF_PERIOD_WIDTH    16
`define PCF_LOCK_WIDTH      20
`endif

//--- pcf_pkg.sv
// Types for the gated clock fanout block
package pcf_pkg;
  typedef enum logic {
    PCF_ACQUIRE,
    PCF_LOCKED
  } pcf_lock_state_e;
endpackage

//--- pcf_clock_fanout.sv
// Clock fanout with two gated banks, feedback output and lock wait
// Overview of operation
// - Nine copies: bank of five, bank of four
// - Bank A enable low holds outputs low
// - Bank A enable high: outputs follow reference
// - Bank B enable low holds outputs low
// - Bank B enable high: outputs follow reference
// - Feedback output ungated, toggles while reference runs
// - Outputs regenerated at fifty percent duty once locked without bypass
// - Feedback aligned to reference edges
// - Stabilization wait after start or change
// - Lock reached after stabilization time
// - Bypass strap buffers reference straight out
// - Reference low forces all clock outputs low in bypass or before lock
`timescale 1ns/1ps
`include "pcf_regs.svh"
module pcf_clock_fanout
  import pcf_pkg::*;
#(
  parameter int unsigned STAB_CYCLES = `PCF_STAB_CYCLES,
  parameter int unsigned PW          = `PCF_PERIOD_WIDTH,
  parameter int unsigned LW          = `PCF_LOCK_WIDTH
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_loop_feedback_in,
  input  wire logic                          i_bank_a_enable,
  input  wire logic                          i_bank_b_enable,
  input  wire logic                          i_analog_supply_bypass_strap,
  output logic [`PCF_BANK_A_WIDTH-1:0]       o_bank_a_clk_out,
  output logic [`PCF_BANK_B_WIDTH-1:0]       o_bank_b_clk_out,
  output logic                               o_loop_feedback_out,
  output logic                               o_lock_valid
);

  localparam logic [LW-1:0] LOCK_DONE = LW'(STAB_CYCLES);
  localparam logic [PW-1:0] PER_MAX   = '1;

  logic            ref_q;
  logic            fb_q;
  logic [PW-1:0]   ref_cnt;
  logic [PW-1:0]   period;
  logic [PW-1:0]   phase;
  logic [PW-1:0]   fb_gap;
  logic [LW-1:0]   lock_cnt;
  pcf_lock_state_e state;

  wire            ref_rise  = i_ref_clk & ~ref_q;
  wire            fb_rise   = i_loop_feedback_in & ~fb_q;
  wire [PW-1:0]   new_per   = (ref_cnt == PER_MAX) ? PER_MAX : PW'(ref_cnt + 1'b1);
  wire            per_chg   = ref_rise && (new_per != period);
  wire [PW-1:0]   fb_limit  = PW'({period, 1'b0});
  wire            fb_lost   = (state == PCF_LOCKED) && (fb_gap > fb_limit);
  wire            restart   = per_chg | fb_lost;
  wire            ref_stop  = (ref_cnt >= period);
  wire            synth_hi  = (phase < (period >> 1)) && !ref_stop;
  wire            locked    = (state == PCF_LOCKED);
  wire            next_core = (i_analog_supply_bypass_strap || !locked) ? i_ref_clk
                                                                        : synth_hi;
  wire            next_a    = next_core & i_bank_a_enable;
  wire            next_b    = next_core & i_bank_b_enable;

  // Reference period measurement and phase
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_q   <= 1'b0;
      fb_q    <= 1'b0;
      ref_cnt <= '0;
      period  <= '0;
      phase   <= '0;
    end else begin
      ref_q   <= i_ref_clk;
      fb_q    <= i_loop_feedback_in;
      ref_cnt <= ref_rise ? '0 : new_per;
      period  <= ref_rise ? new_per : period;
      phase   <= ref_rise ? '0 : new_per;
    end
  end

  // Feedback edge supervision
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fb_gap <= '0;
    end else begin
      fb_gap <= (fb_rise || !locked) ? '0 : ((fb_gap == PER_MAX) ? PER_MAX : PW'(fb_gap + 1'b1));
    end
  end

  // Lock wait counter
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      lock_cnt <= '0;
      state    <= PCF_ACQUIRE;
    end else begin
      unique case (state)
        PCF_ACQUIRE: begin
          lock_cnt <= restart ? '0 : LW'(lock_cnt + 1'b1);
          if (!restart && (lock_cnt == LOCK_DONE - 1'b1)) begin
            state <= PCF_LOCKED;
          end
        end
        PCF_LOCKED: begin
          if (restart) begin
            lock_cnt <= '0;
            state    <= PCF_ACQUIRE;
          end
        end
      endcase
    end
  end

  // Output drivers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bank_a_clk_out    <= '0;
      o_bank_b_clk_out    <= '0;
      o_loop_feedback_out <= 1'b0;
      o_lock_valid        <= 1'b0;
    end else begin
      o_bank_a_clk_out    <= {`PCF_BANK_A_WIDTH{next_a}};
      o_bank_b_clk_out    <= {`PCF_BANK_B_WIDTH{next_b}};
      o_loop_feedback_out <= next_core;
      o_lock_valid        <= locked;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_acquire_done;
    (state == PCF_ACQUIRE) && !restart && (lock_cnt == LOCK_DONE - 1'b1);
  endsequence

  a_bank_a_off: assert property (!i_bank_a_enable |=> o_bank_a_clk_out == '0)
    else $error("bank A not low while disabled");
  a_bank_a_on: assert property (i_bank_a_enable |=>
    o_bank_a_clk_out == {`PCF_BANK_A_WIDTH{o_loop_feedback_out}})
    else $error("bank A not following core clock");
  a_bank_b_off: assert property (!i_bank_b_enable |=> o_bank_b_clk_out == '0)
    else $error("bank B not low while disabled");
  a_bank_b_on: assert property (i_bank_b_enable |=>
    o_bank_b_clk_out == {`PCF_BANK_B_WIDTH{o_loop_feedback_out}})
    else $error("bank B not following core clock");
  a_bypass_path: assert property (i_analog_supply_bypass_strap |=>
    o_loop_feedback_out == $past(i_ref_clk))
    else $error("bypass does not buffer reference");
  a_ref_low_out: assert property ((i_analog_supply_bypass_strap || !locked) && !i_ref_clk
    |=> !o_loop_feedback_out && o_bank_a_clk_out == '0 && o_bank_b_clk_out == '0)
    else $error("outputs high while reference low");
  a_duty_half: assert property (locked && !i_analog_supply_bypass_strap && ref_rise
    && (period > 2'd3) ##1 (locked && !i_analog_supply_bypass_strap)
    |=> o_loop_feedback_out)
    else $error("regenerated clock not high after reference edge");
  a_lock_wait: assert property (s_acquire_done |=> locked ##1 o_lock_valid)
    else $error("lock flag not raised after wait");
  a_lock_restart: assert property (restart |=> !locked ##1 !o_lock_valid)
    else $error("lock not dropped on reference change");

  // Regenerated clock phases while locked
  sequence s_locked_run;
    locked && !i_analog_supply_bypass_strap;
  endsequence

  sequence s_ref_idle;
    locked && !i_analog_supply_bypass_strap && ref_stop;
  endsequence

  // Lock wait counter behaviour
  a_acquire_count: assert property (
    (state == PCF_ACQUIRE) && !restart |=> lock_cnt == LW'($past(lock_cnt) + 1'b1))
    else $error("lock wait counter did not advance");

  a_restart_clear: assert property (
    restart |=> lock_cnt == '0)
    else $error("lock wait counter not cleared on restart");

  a_lock_hold: assert property (
    locked && !restart |=> locked)
    else $error("lock lost without restart");

  a_lock_flag_src: assert property (
    $rose(o_lock_valid) |-> $past(locked))
    else $error("lock flag raised without locked state");

  // Feedback supervision and period measurement
  a_fb_lost_drop: assert property (
    fb_lost |=> !locked ##1 !o_lock_valid)
    else $error("lock kept after feedback loss");

  a_period_meas: assert property (
    ref_rise |=> period == $past(new_per))
    else $error("reference period not captured");

  a_phase_reset: assert property (
    ref_rise |=> phase == '0)
    else $error("phase not restarted on reference edge");

  // Output levels
  a_synth_low: assert property (
    s_locked_run ##0 !synth_hi |=> !o_loop_feedback_out)
    else $error("regenerated clock high in low half");

  a_stop_low: assert property (
    s_ref_idle |=> !o_loop_feedback_out)
    else $error("output high with stopped reference");

  a_fb_ungated: assert property (
    !i_bank_a_enable && !i_bank_b_enable && i_ref_clk
    && (i_analog_supply_bypass_strap || !locked) |=> o_loop_feedback_out)
    else $error("feedback output gated by bank enables");

endmodule // pcf_clock_fanout

//--- pcf_ref_source.sv
// Reference clock source model
`timescale 1ns/1ps
module pcf_ref_source (
  input  wire logic       i_clk,
  input  wire logic       i_run,
  input  wire logic [3:0] i_hi,
  input  wire logic [3:0] i_lo,
  output logic            o_ref = 1'b0
);
  logic [3:0] cnt = 4'h0;
  // Period set by i_hi and i_lo, stands low when stopped
  always @(posedge i_clk) begin
    if (!i_run) begin
      o_ref <= 1'b0;
      cnt <= 4'h0;
    end else if (cnt == 4'h0) begin
      o_ref <= ~o_ref;
      cnt <= (o_ref ? i_lo : i_hi) - 4'h1;
    end else
      cnt <= cnt - 4'h1;
  end
endmodule // pcf_ref_source

//--- pcf_clock_fanout_test.sv
// Testbench for the clock fanout block
`timescale 1ns/1ps
module pcf_clock_fanout_test;
  logic i_clk = 1'b0, i_rst = 1'b1, run = 1'b1, en_a = 1'b1, en_b = 1'b1, strap = 1'b0;
  logic [3:0] hi = 4'h5, lo = 4'h5, bank_b;
  logic [4:0] bank_a;
  logic ref_clk, ref_q, a_q, b_q, fb, lock;
  int n_errors = 0, n_compared = 0;
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) {ref_q, a_q, b_q} <= {ref_clk, en_a, en_b};
  pcf_ref_source src (.i_clk(i_clk), .i_run(run), .i_hi(hi), .i_lo(lo), .o_ref(ref_clk));
  pcf_clock_fanout #(.STAB_CYCLES(64)) dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_ref_clk(ref_clk), .i_loop_feedback_in(fb), .i_bank_a_enable(en_a),
    .i_bank_b_enable(en_b), .i_analog_supply_bypass_strap(strap), .o_bank_a_clk_out(bank_a),
    .o_bank_b_clk_out(bank_b), .o_loop_feedback_out(fb), .o_lock_valid(lock));
  task automatic check(string what, logic [4:0] exp, logic [4:0] got);
    n_compared++;
    if (exp !== got) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_lock();
    int n = 0;
    while (lock !== 1'b1 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    check("lock_early", 5'(n >= 64), 5'h01);
    check("lock_late", 5'(n <= 120), 5'h01);
  endtask
  task automatic t_duty();
    int h = 0, g = 0;
    @(posedge i_clk) {hi, lo} <= 8'h46;
    repeat (120) @(negedge i_clk);
    repeat (10) begin
      @(negedge i_clk);
      h += fb;
      g += bank_a[4];
    end
    check("fb_high", 5'(h), 5'h05);
    check("bank_high", 5'(g), 5'h05);
    check("lock_kept", {4'h0, lock}, 5'h01);
  endtask
  task automatic t_restart();
    @(posedge i_clk) {hi, lo} <= 8'h66;
    repeat (40) @(negedge i_clk);
    check("lock_drop", {4'h0, lock}, 5'h00);
  endtask
  task automatic t_stop();
    @(posedge i_clk) run <= 1'b0;
    repeat (40) @(negedge i_clk);
    check("stop_a", bank_a, 5'h00);
    check("stop_fb", {bank_b, fb}, 5'h00);
  endtask
  task automatic t_bypass();
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk) {run, strap, en_a, en_b} <= {2'b11, k[1:0]};
      repeat (14) begin
        @(negedge i_clk);
        check("a", {5{ref_q & a_q}}, bank_a);
        check("b", {1'b0, {4{ref_q & b_q}}}, {1'b0, bank_b});
        check("fb", {4'h0, ref_q}, {4'h0, fb});
      end
    end
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    t_lock();
    t_duty();
    t_restart();
    t_stop();
    t_bypass();
    results();
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    n_errors++;
    results();
  end
endmodule // pcf_clock_fanout_test
